// [src/cgps_top.sv]
// Clock generator and power-save sequencer with its register file.
// ------------------------------------------------------------
// How it works
// - System clock is oscillator direct when path bit 0, times-8 multiplier when 1.
// - Two-bit divider gives full, half, quarter or eighth clock; resets to 3.
// - Divider, power-save and watch registers update only on protected writes.
// - Standby bit 1 enters standby; software sets divider to 3 first.
// - Interrupt wake block bit 0 lets maskable interrupts end standby; 1 does not.
// - Kind bit picks idle at 0, stop at 1, used only on standby.
// - Halt stops CPU; idle also bus, peripheral, watchdog; stop stops all.
// - Settle code 4..8 selects 2^14..2^18 oscillator periods; resets to 4.
// - Settle select register takes byte writes only, never single-bit writes.
// - Entering stop halts oscillator and multiplier and clears settle counter.
// - Stop wake restarts oscillator, counts settle time, multiplier starts at half.
// - Second half is lock wait; afterwards clocks resume in prior state.
// - After reset multiplier stays off for a fixed time, then lock counted.
// - Lock done: counter cleared, CPU leaves reset direct path, divide by eight.
// - Watch enable bit cannot be cleared by software, only by reset.
// - Watch is suspended during stop wake counting and debug break.
// - Watch spots stopped oscillator and forces motor timer outputs to float.
// ------------------------------------------------------------
module cgps_top #(
    parameter logic [19:0] RST_FIX_TICKS  = 20'h04000,
    parameter logic [19:0] RST_LOCK_TICKS = 20'h02000,
    parameter logic [4:0]  SETTLE_CUT     = 5'h00
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Register port
    input  wire logic [31:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic        bit_op,
    input  wire logic [2:0]  bit_sel,
    input  wire logic        prot_wr_en,
    output logic      [7:0]  rdata_q,
    // Events and pins
    input  wire logic        osc_tick,
    input  wire logic        osc_level,
    input  wire logic        maskable_irq_request,
    input  wire logic        nmi_req,
    input  wire logic        halt_req,
    input  wire logic        dbg_break,
    input  wire logic        multiplier_range_pin,
    // Clock controls
    output logic             osc_run_q,
    output logic             pll_run_q,
    output logic             multiplier_path_q,
    output logic      [1:0]  cpu_div_q,
    output logic             cpu_clk_en_q,
    output logic             bus_clk_en_q,
    output logic             periph_clk_en_q,
    output logic             wdt_clk_en_q,
    output logic             pll_range_q,
    output logic             cpu_rst_n_q,
    output logic             motor_hiz_q
);
    import cgps_pkg::*;

    typedef struct packed {
        cgps_state_e state;
        logic [19:0] settle_counter;
        logic        path;
        logic [1:0]  div;
        logic        iwb;
        logic        stb;
        logic        stop;
        logic [3:0]  code;
        logic        wen;
        logic        cpu_rst_n;
        logic        osc;
        logic        pll;
        logic        cpu;
        logic        bus;
        logic        per;
        logic        wdt;
        logic        rng;
        logic [7:0]  rdata;
    } cgps_st_s;

    cgps_st_s st_q;
    cgps_st_s st_d;

    logic        wake_ok;
    logic        suspend;
    logic        hiz;
    logic [19:0] len;
    logic [7:0]  wv;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [19:0] settle_len(input logic [3:0] c);
        logic [4:0] sh;
        sh = 5'(c) + 5'(SETTLE_BASE) - SETTLE_CUT;
        return 20'h00001 << sh;
    endfunction : settle_len

    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] wd,
                                         input logic       bo,
                                         input logic [2:0] sel);
        logic [7:0] m;
        m = 8'h01 << sel;
        return bo ? ((old & ~m) | (wd & m)) : wd;
    endfunction : merge

    function automatic logic is_wr(input logic [31:0] a,
                                   input logic [31:0] target);
        return (a == target);
    endfunction : is_wr

    // A settling oscillator, a deliberately stopped one or a debug break
    // hides the oscillator from the watch, so a failure during a break is masked.
    assign suspend = dbg_break || !st_q.osc
                     || st_q.state == ST_WAKE || st_q.state == ST_LOCK;
    assign wake_ok = nmi_req || (maskable_irq_request && !st_q.iwb);
    assign len     = settle_len(st_q.code);

    cgps_osc_watch u_watch (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .enable    (st_q.wen),
        .suspend   (suspend),
        .osc_level (osc_level),
        .stopped_q (hiz)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d       = st_q;
        st_d.rdata = 8'h00;
        wv         = 8'h00;
        // Register writes.
        if (wr) begin
            if (is_wr(addr, ADR_MULT_MODE)) begin
                wv = merge({6'h00, st_q.path, 1'b1}, wdata, bit_op, bit_sel);
                st_d.path = wv[BIT_PATH];
            end
            if (is_wr(addr, ADR_CPU_DIV) && prot_wr_en) begin
                wv = merge({6'h00, st_q.div}, wdata, bit_op, bit_sel);
                st_d.div = wv[1:0];
            end
            if (is_wr(addr, ADR_PSC) && prot_wr_en) begin
                wv = merge({3'h0, st_q.iwb, 2'h0, st_q.stb, 1'b0},
                           wdata, bit_op, bit_sel);
                st_d.iwb = wv[BIT_IWB];
                st_d.stb = wv[BIT_STB];
            end
            if (is_wr(addr, ADR_KIND)) begin
                wv = merge({7'h00, st_q.stop}, wdata, bit_op, bit_sel);
                st_d.stop = wv[BIT_STOP];
            end
            if (is_wr(addr, ADR_SETTLE) && !bit_op
                && wdata[3:0] >= SETTLE_MIN && wdata[3:0] <= SETTLE_MAX) begin
                st_d.code = wdata[3:0];
            end
            if (is_wr(addr, ADR_WATCH) && prot_wr_en) begin
                wv = merge({7'h00, st_q.wen}, wdata, bit_op, bit_sel);
                st_d.wen = st_q.wen | wv[BIT_WEN];
            end
        end
        // Register reads; unmapped addresses read zero.
        if (rd) begin
            if (addr == ADR_MULT_MODE) begin
                st_d.rdata = {6'h00, st_q.path, 1'b1};
            end else if (addr == ADR_CPU_DIV) begin
                st_d.rdata = {6'h00, st_q.div};
            end else if (addr == ADR_PSC) begin
                st_d.rdata = {3'h0, st_q.iwb, 2'h0, st_q.stb, 1'b0};
            end else if (addr == ADR_KIND) begin
                st_d.rdata = {7'h00, st_q.stop};
            end else if (addr == ADR_SETTLE) begin
                st_d.rdata = {4'h0, st_q.code};
            end else if (addr == ADR_WATCH) begin
                st_d.rdata = {7'h00, st_q.wen};
            end
        end
        // Sequencer.
        unique case (st_q.state)
            ST_RST_FIX: begin
                st_d.rng = multiplier_range_pin;
                if (osc_tick) begin
                    st_d.settle_counter = st_q.settle_counter + 20'h00001;
                end
                if (st_q.settle_counter == RST_FIX_TICKS) begin
                    st_d.state          = ST_RST_LOCK;
                    st_d.settle_counter = OST_CLEAR;
                end
            end
            ST_RST_LOCK: begin
                if (osc_tick) begin
                    st_d.settle_counter = st_q.settle_counter + 20'h00001;
                end
                if (st_q.settle_counter == RST_LOCK_TICKS) begin
                    st_d.state          = ST_RUN;
                    st_d.settle_counter = OST_CLEAR;
                    st_d.cpu_rst_n      = 1'b1;
                end
            end
            ST_RUN: begin
                if (st_q.stb) begin
                    st_d.state = st_q.stop ? ST_STOP : ST_IDLE;
                    st_d.settle_counter = OST_CLEAR;
                end else if (halt_req) begin
                    st_d.state = ST_HALT;
                end
            end
            ST_HALT: begin
                if (maskable_irq_request || nmi_req) begin
                    st_d.state = ST_RUN;
                end
            end
            ST_IDLE: begin
                if (wake_ok) begin
                    st_d.state = ST_RUN;
                    st_d.stb   = 1'b0;
                end
            end
            ST_STOP: begin
                if (wake_ok) begin
                    st_d.state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (osc_tick) begin
                    st_d.settle_counter = st_q.settle_counter + 20'h00001;
                end
                if (st_q.settle_counter == (len >> 1)) begin
                    st_d.state = ST_LOCK;
                end
            end
            ST_LOCK: begin
                if (osc_tick) begin
                    st_d.settle_counter = st_q.settle_counter + 20'h00001;
                end
                if (st_q.settle_counter == len) begin
                    st_d.state          = ST_RUN;
                    st_d.stb            = 1'b0;
                    st_d.settle_counter = OST_CLEAR;
                end
            end
            default: begin
                st_d.state = ST_RUN;
            end
        endcase
        // Clock gating follows the state being entered, so the gates
        // never lag the mode by a cycle.
        st_d.osc = st_d.state != ST_STOP;
        st_d.pll = !(st_d.state inside {ST_STOP, ST_WAKE, ST_RST_FIX});
        st_d.cpu = st_d.state inside {ST_RUN, ST_RST_FIX, ST_RST_LOCK};
        st_d.bus = st_d.state inside {ST_RUN, ST_HALT, ST_RST_FIX, ST_RST_LOCK};
        st_d.per = st_d.state inside {ST_RUN, ST_HALT};
        st_d.wdt = st_d.state inside {ST_RUN, ST_HALT};
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q       <= '0;
            st_q.state <= ST_RST_FIX;
            st_q.div   <= RST_DIV;
            st_q.code  <= RST_SETTLE;
            st_q.osc   <= 1'b1;
            st_q.cpu   <= 1'b1;
            st_q.bus   <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata_q           = st_q.rdata;
    assign osc_run_q         = st_q.osc;
    assign pll_run_q         = st_q.pll;
    assign multiplier_path_q = st_q.path;
    assign cpu_div_q         = st_q.div;
    assign cpu_clk_en_q      = st_q.cpu;
    assign bus_clk_en_q      = st_q.bus;
    assign periph_clk_en_q   = st_q.per;
    assign wdt_clk_en_q      = st_q.wdt;
    assign pll_range_q       = st_q.rng;
    assign cpu_rst_n_q       = st_q.cpu_rst_n;
    assign motor_hiz_q       = hiz;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    path_select_a: assert property (
        (wr && !bit_op && addr == ADR_MULT_MODE) |=> multiplier_path_q == $past(wdata[1]))
        else $error("path bit not taken");

    div_update_a: assert property (
        (wr && !bit_op && prot_wr_en && addr == ADR_CPU_DIV) |=> cpu_div_q == $past(wdata[1:0]))
        else $error("divider not written");

    div_protect_a: assert property (
        (wr && !prot_wr_en && addr == ADR_CPU_DIV) |=> $stable(cpu_div_q))
        else $error("unprotected divider write took effect");

    settle_byte_a: assert property (
        (wr && bit_op && addr == ADR_SETTLE) |=> $stable(st_q.code))
        else $error("bit write changed settle code");

    watch_sticky_a: assert property (
        st_q.wen |=> st_q.wen)
        else $error("watch enable cleared");

    stop_gates_a: assert property (
        st_q.state == ST_STOP |-> !osc_run_q && !pll_run_q && st_q.settle_counter == OST_CLEAR)
        else $error("stop mode left clocks running");

    wake_pll_a: assert property (
        st_q.state == ST_WAKE |-> osc_run_q && !pll_run_q && !cpu_clk_en_q)
        else $error("multiplier ran in first half of wake");

    irq_block_a: assert property (
        (st_q.state == ST_IDLE && st_q.iwb && !nmi_req) |=> st_q.state == ST_IDLE)
        else $error("blocked interrupt ended idle");

    halt_gates_a: assert property (
        st_q.state == ST_HALT |-> !cpu_clk_en_q && bus_clk_en_q && periph_clk_en_q)
        else $error("halt gating wrong");

    reset_exit_a: assert property (
        $rose(cpu_rst_n_q) |-> st_q.settle_counter == OST_CLEAR && pll_run_q
                               && !multiplier_path_q && cpu_div_q == RST_DIV)
        else $error("reset exit state wrong");

endmodule : cgps_top

// [shared/cgps_pkg.sv]
// Constants shared by the clock generator and power-save sequencer.
package cgps_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [31:0] ADR_MULT_MODE = 32'hfffff82c;
    localparam logic [31:0] ADR_CPU_DIV   = 32'h0ffff828;
    localparam logic [31:0] ADR_PSC       = 32'hfffff1fe;
    localparam logic [31:0] ADR_KIND      = 32'hfffff820;
    localparam logic [31:0] ADR_SETTLE    = 32'h0ffff6c0;
    localparam logic [31:0] ADR_WATCH     = 32'hfffff870;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_PATH     = 1;
    localparam int BIT_MODE_ONE = 0;
    localparam int BIT_IWB      = 4;
    localparam int BIT_STB      = 1;
    localparam int BIT_STOP     = 0;
    localparam int BIT_WEN      = 0;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [1:0]  RST_DIV     = 2'h3;
    localparam logic [3:0]  RST_SETTLE  = 4'h4;
    localparam logic [3:0]  SETTLE_MIN  = 4'h4;
    localparam logic [3:0]  SETTLE_MAX  = 4'h8;
    localparam int          SETTLE_BASE = 10;
    localparam logic [19:0] OST_CLEAR   = 20'h00000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ     = 250;
    localparam int WATCH_NS    = 250;
    localparam int WATCH_CYC   = WATCH_NS * CLK_MHZ / 1000;
    localparam logic [7:0] WATCH_LIM = 8'(WATCH_CYC);

    typedef enum logic [2:0] {
        ST_RST_FIX  = 3'b100,
        ST_RST_LOCK = 3'b101,
        ST_RUN      = 3'b001,
        ST_HALT     = 3'b000,
        ST_IDLE     = 3'b011,
        ST_STOP     = 3'b010,
        ST_WAKE     = 3'b110,
        ST_LOCK     = 3'b111
    } cgps_state_e;

endpackage : cgps_pkg

// [src/cgps_osc_watch.sv]
// Oscillator stop detector sampled by the internal oscillation clock.
module cgps_osc_watch (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic arst_n,
    // Control
    input  wire logic enable,
    input  wire logic suspend,
    input  wire logic osc_level,
    // Result
    output logic      stopped_q
);
    import cgps_pkg::*;

    typedef struct packed {
        logic       prev;
        logic [7:0] idle;
        logic       stop;
    } cgps_watch_s;

    cgps_watch_s w_q;
    cgps_watch_s w_d;

    // ------------------------------------------------------------
    // Edge timeout
    // ------------------------------------------------------------
    // The flag is sticky: outputs stay off until a reset, since a
    // restarted oscillator may still be unreliable.
    always_comb begin
        w_d      = w_q;
        w_d.prev = osc_level;
        if (!enable || suspend || (osc_level != w_q.prev)) begin
            w_d.idle = 8'h00;
        end else if (w_q.idle != WATCH_LIM) begin
            w_d.idle = w_q.idle + 8'h01;
        end
        if (enable && !suspend && w_q.idle == WATCH_LIM) begin
            w_d.stop = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            w_q <= '0;
        end else begin
            w_q <= w_d;
        end
    end

    assign stopped_q = w_q.stop;

endmodule : cgps_osc_watch

// [testbench/tb_top.sv]
// Self-checking bench for the clock generator and power-save sequencer.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cgps_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        mclk   = 1'b0;
    logic        arst_n = 1'b0;
    logic [31:0] addr   = 32'h0;
    logic [7:0]  wdata  = 8'h00;
    logic [2:0]  bit_sel = 3'h0;
    logic        wr = 1'b0, rd = 1'b0, bit_op = 1'b0, prot_wr_en = 1'b0;
    logic        osc_tick = 1'b0, osc_level = 1'b0, irq = 1'b0, nmi_req = 1'b0;
    logic        halt_req = 1'b0, dbg_break = 1'b0, range_pin = 1'b1, osc_dead = 1'b0;
    logic [7:0]  rdata_q;
    logic [1:0]  cpu_div_q, tdiv = 2'h0;
    logic        osc_run_q, pll_run_q, path_q, cpu_en, bus_en, per_en, wdt_en, range_q, cpu_rst_n_q, hiz;
    int          miscompares = 0, checks_done = 0, cycles = 0, nticks = 0;

    cgps_top #(.RST_FIX_TICKS(20'h00008), .RST_LOCK_TICKS(20'h00008), .SETTLE_CUT(5'h0a)) u_dut (
        .mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .bit_op(bit_op),
        .bit_sel(bit_sel), .prot_wr_en(prot_wr_en), .rdata_q(rdata_q), .osc_tick(osc_tick),
        .osc_level(osc_level), .maskable_irq_request(irq), .nmi_req(nmi_req), .halt_req(halt_req),
        .dbg_break(dbg_break), .multiplier_range_pin(range_pin), .osc_run_q(osc_run_q),
        .pll_run_q(pll_run_q), .multiplier_path_q(path_q), .cpu_div_q(cpu_div_q), .cpu_clk_en_q(cpu_en),
        .bus_clk_en_q(bus_en), .periph_clk_en_q(per_en), .wdt_clk_en_q(wdt_en), .pll_range_q(range_q),
        .cpu_rst_n_q(cpu_rst_n_q), .motor_hiz_q(hiz));

    // ------------------------------------------------------------
    // Clock, oscillator stand-in and watchdog on the run
    // ------------------------------------------------------------
    always #2 mclk = ~mclk;

    // The oscillator only ticks and toggles while the block lets it run, so a stop really looks dead.
    always @(posedge mclk) begin
        tdiv      <= tdiv + 2'h1;
        osc_tick  <= (osc_run_q === 1'b1) && (tdiv == 2'h3);
        osc_level <= (osc_run_q === 1'b1 && !osc_dead) ? ~osc_level : osc_level;
        if (osc_tick) nticks <= nticks + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr_reg(input logic [31:0] a, input logic [7:0] d, input logic p,
                          input logic bo = 1'b0, input logic [2:0] bs = 3'h0);
        @(posedge mclk);
        addr <= a; wdata <= d; prot_wr_en <= p; bit_op <= bo; bit_sel <= bs; wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0; prot_wr_en <= 1'b0; bit_op <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic rd_chk(input string name, input logic [31:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a; rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(name, rdata_q, exp);
    endtask : rd_chk

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc

    task automatic wrap_up();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        int i;
        cyc(5);
        chk("pll in reset", pll_run_q, 1'b0);
        chk("cpu rst in reset", cpu_rst_n_q, 1'b0);
        @(posedge mclk) arst_n <= 1'b1;
        cyc(10);
        chk("pll fixed wait", pll_run_q, 1'b0);
        for (i = 0; i < 300 && pll_run_q !== 1'b1; i++) cyc(1);
        chk("pll lock phase", {cpu_rst_n_q, pll_run_q}, 8'h01);
        for (i = 0; i < 300 && cpu_rst_n_q !== 1'b1; i++) cyc(1);
        chk("cpu released", cpu_rst_n_q, 1'b1);
        chk("path direct", path_q, 1'b0);
        chk("div eighth", cpu_div_q, 2'h3);
        chk("range pin", range_q, 1'b1);
        rd_chk("settle rst", ADR_SETTLE, 8'h04);
        rd_chk("div rst", ADR_CPU_DIV, 8'h03);
        rd_chk("psc rst", ADR_PSC, 8'h00);
        rd_chk("kind rst", ADR_KIND, 8'h00);
        rd_chk("watch rst", ADR_WATCH, 8'h00);
        rd_chk("unmapped", 32'hfffff000, 8'h00);
    endtask : t_reset

    task automatic t_divider();
        wr_reg(ADR_MULT_MODE, 8'h03, 1'b0);
        chk("path pll", path_q, 1'b1);
        rd_chk("mode read", ADR_MULT_MODE, 8'h03);
        wr_reg(ADR_CPU_DIV, 8'h00, 1'b0);
        chk("div unprotected", cpu_div_q, 2'h3);
        for (int k = 0; k < 4; k++) begin
            wr_reg(ADR_CPU_DIV, 8'(k), 1'b1);
            chk("div out", cpu_div_q, 8'(k));
            rd_chk("div read", ADR_CPU_DIV, 8'(k));
        end
    endtask : t_divider

    task automatic t_settle();
        wr_reg(ADR_SETTLE, 8'h01, 1'b0, 1'b1, 3'h0);
        rd_chk("settle bitop", ADR_SETTLE, 8'h04);
        wr_reg(ADR_SETTLE, 8'h09, 1'b0);
        rd_chk("settle high", ADR_SETTLE, 8'h04);
        wr_reg(ADR_SETTLE, 8'h03, 1'b0);
        rd_chk("settle low", ADR_SETTLE, 8'h04);
        wr_reg(ADR_SETTLE, 8'h05, 1'b0);
        rd_chk("settle five", ADR_SETTLE, 8'h05);
        wr_reg(ADR_WATCH, 8'h01, 1'b0);
        rd_chk("watch unprotected", ADR_WATCH, 8'h00);
        wr_reg(ADR_WATCH, 8'h01, 1'b1);
        wr_reg(ADR_WATCH, 8'h00, 1'b1);
        rd_chk("watch sticky", ADR_WATCH, 8'h01);
    endtask : t_settle

    task automatic t_halt_idle();
        int i;
        @(posedge mclk) halt_req <= 1'b1;
        @(posedge mclk) halt_req <= 1'b0;
        cyc(2);
        chk("halt gates", {cpu_en, bus_en, per_en}, 8'h03);
        @(posedge mclk) irq <= 1'b1;
        @(posedge mclk) irq <= 1'b0;
        cyc(2);
        chk("halt release", cpu_en, 1'b1);
        wr_reg(ADR_CPU_DIV, 8'h03, 1'b1);
        wr_reg(ADR_KIND, 8'h00, 1'b0);
        wr_reg(ADR_PSC, 8'h12, 1'b1);
        cyc(1);
        chk("idle gates", {osc_run_q, pll_run_q, cpu_en, bus_en, per_en, wdt_en}, 8'h30);
        @(posedge mclk) irq <= 1'b1;
        cyc(20);
        chk("irq blocked", bus_en, 1'b0);
        @(posedge mclk) nmi_req <= 1'b1;
        for (i = 0; i < 20 && bus_en !== 1'b1; i++) cyc(1);
        chk("nmi wake", {bus_en, per_en}, 8'h03);
        @(posedge mclk);
        nmi_req <= 1'b0;
        irq     <= 1'b0;
        wr_reg(ADR_PSC, 8'h02, 1'b1);
        cyc(1);
        chk("idle again", bus_en, 1'b0);
        @(posedge mclk) irq <= 1'b1;
        for (i = 0; i < 20 && bus_en !== 1'b1; i++) cyc(1);
        chk("irq wake", {cpu_en, bus_en}, 8'h03);
        @(posedge mclk) irq <= 1'b0;
    endtask : t_halt_idle

    task automatic t_stop();
        int i, n0;
        wr_reg(ADR_CPU_DIV, 8'h03, 1'b1);
        wr_reg(ADR_KIND, 8'h01, 1'b0, 1'b1, 3'h0);
        wr_reg(ADR_PSC, 8'h02, 1'b1);
        cyc(2);
        chk("stop gates", {osc_run_q, pll_run_q, cpu_en, bus_en, per_en, wdt_en}, 8'h00);
        // Staying stopped longer than the watch timeout proves the watch is held off.
        cyc(80);
        chk("stop holds", osc_run_q, 1'b0);
        @(posedge mclk) irq <= 1'b1;
        for (i = 0; i < 20 && osc_run_q !== 1'b1; i++) cyc(1);
        n0 = nticks;
        chk("wake osc only", {osc_run_q, pll_run_q, bus_en}, 8'h04);
        // A silent oscillator during the settle count must not trip the watch.
        @(posedge mclk);
        irq      <= 1'b0;
        osc_dead <= 1'b1;
        for (i = 0; i < 300 && pll_run_q !== 1'b1; i++) cyc(1);
        // Code five is 32 ticks after the cut, so the multiplier starts at the midpoint.
        chk("half count", (nticks - n0 >= 15) && (nticks - n0 <= 17), 1'b1);
        chk("lock still gated", bus_en, 1'b0);
        for (i = 0; i < 300 && bus_en !== 1'b1; i++) cyc(1);
        chk("full count", (nticks - n0 >= 31) && (nticks - n0 <= 33), 1'b1);
        chk("resumed", {cpu_en, per_en, wdt_en, path_q}, 8'h0f);
        @(posedge mclk) osc_dead <= 1'b0;
        rd_chk("stb cleared", ADR_PSC, 8'h00);
        chk("watch quiet", hiz, 1'b0);
    endtask : t_stop

    task automatic t_watch();
        int i;
        @(posedge mclk);
        dbg_break <= 1'b1;
        osc_dead  <= 1'b1;
        cyc(100);
        chk("break suspends", hiz, 1'b0);
        @(posedge mclk) dbg_break <= 1'b0;
        for (i = 0; i < 100 && hiz !== 1'b1; i++) cyc(1);
        chk("stop detected", hiz, 1'b1);
        // Only a reset may clear the float request and the watch enable.
        @(posedge mclk);
        arst_n   <= 1'b0;
        osc_dead <= 1'b0;
        cyc(5);
        chk("hiz after reset", hiz, 1'b0);
        chk("path after reset", path_q, 1'b0);
        @(posedge mclk) arst_n <= 1'b1;
        for (i = 0; i < 300 && cpu_rst_n_q !== 1'b1; i++) cyc(1);
        chk("cpu released again", cpu_rst_n_q, 1'b1);
        rd_chk("watch after reset", ADR_WATCH, 8'h00);
    endtask : t_watch

    initial begin
        t_reset();
        t_divider();
        t_settle();
        t_halt_idle();
        t_stop();
        t_watch();
        wrap_up();
    end

endmodule : tb_top
